// ==== include/rtacnt_defines.svh ====
// Register offsets, field positions, reset values and limits of the ramp/tracking counter
`ifndef RTACNT_DEFINES_SVH
`define RTACNT_DEFINES_SVH

// Register byte addresses
`define RTACNT_ADDR_CTRL 8'h00
`define RTACNT_ADDR_STATUS 8'h04
`define RTACNT_ADDR_COUNT 8'h08

// Control register fields
`define RTACNT_CTRL_CONV_LSB 0
`define RTACNT_CTRL_CONV_MSB 1
`define RTACNT_CTRL_CLEAR_BIT 2
`define RTACNT_CTRL_RESET 2'h0

// Status register fields
`define RTACNT_STAT_STATE_LSB 0
`define RTACNT_STAT_STATE_MSB 1
`define RTACNT_STAT_HALT_BIT 2
`define RTACNT_STAT_DACMODE_BIT 3
`define RTACNT_STAT_DIRDOWN_BIT 4
`define RTACNT_STAT_OVER_BIT 5
`define RTACNT_STAT_CODE_LSB 8
`define RTACNT_STAT_CODE_MSB 15

// Comparator lanes inside the synchroniser
`define RTACNT_CMP_RAMP 0
`define RTACNT_CMP_UPPER 1
`define RTACNT_CMP_LOWER 2
`define RTACNT_CMP_WIDTH 3

// Counter limits
`define RTACNT_FULL_SCALE 8'hff
`define RTACNT_ZERO 8'h00
`define RTACNT_CODE_RESET 8'h00

`endif

// ==== include/rtacnt_pkg.sv ====
// Types shared by the ramp/tracking counter modules
package rtacnt_pkg;

  // Ramp conversion progress, Gray coded along idle, run, done
  typedef enum logic [1:0] {
    RTACNT_ST_IDLE = 2'b00,
    RTACNT_ST_RUN = 2'b01,
    RTACNT_ST_DONE = 2'b11
  } rtacnt_state_t;

  // Source of counting control
  typedef enum logic [1:0] {
    RTACNT_CONV_PINS = 2'b00,
    RTACNT_CONV_RAMP = 2'b01,
    RTACNT_CONV_TRACK = 2'b10,
    RTACNT_CONV_SPARE = 2'b11
  } rtacnt_conv_t;

endpackage

// ==== include/rtacnt_sync_if.sv ====
// Comparator lines, raw and synchronised, between top and synchroniser
interface rtacnt_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

// ==== verilog/rtacnt_cmp_sync.sv ====
// Two-stage synchroniser for the comparator lines
`include "rtacnt_defines.svh"
module rtacnt_cmp_sync
  import rtacnt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  rtacnt_sync_if.snk cmp
);

  logic [`RTACNT_CMP_WIDTH-1:0] meta_r;
  logic [`RTACNT_CMP_WIDTH-1:0] meta_nxt;
  logic [`RTACNT_CMP_WIDTH-1:0] sync_r;
  logic [`RTACNT_CMP_WIDTH-1:0] sync_nxt;

  // First stage only feeds the second
  always_comb begin
    meta_nxt = cmp.raw;
    sync_nxt = meta_r;
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign cmp.synced = sync_r;

endmodule // rtacnt_cmp_sync

// ==== verilog/rtacnt_top.sv ====
// Ramp and tracking converter counter control with register port
//
// Added by the designer: the strobed register port and the register addresses.
`include "rtacnt_defines.svh"
module rtacnt_top
  import rtacnt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ext_rst_n,
  input wire logic wrap_sel,
  input wire logic count_up_n,
  input wire logic count_down_n,
  input wire logic ramp_comparator,
  input wire logic upper_threshold_comparator,
  input wire logic lower_threshold_comparator,
  input wire logic [7:0] data_port_in,
  output logic [7:0] data_port_out,
  output logic data_port_oe_n,
  output logic [7:0] dac_code,
  output logic conv_done
);

  // One counting step; returns {direction_down, count}
  function automatic logic [8:0] rtacnt_step(
    input logic [7:0] cnt,
    input logic up_n,
    input logic dn_n,
    input logic wrap,
    input logic dir_down
  );
    logic [7:0] nxt;
    logic dir;
    nxt = cnt;
    dir = dir_down;
    if (!up_n && dn_n) begin
      // Count up
      dir = 1'b0;
      if (cnt != `RTACNT_FULL_SCALE) begin
        nxt = cnt + 8'h01;
      end else if (wrap) begin
        nxt = `RTACNT_ZERO;
      end else begin
        nxt = cnt;
      end
    end else if (up_n && !dn_n) begin
      // Count down
      dir = 1'b1;
      if (cnt != `RTACNT_ZERO) begin
        nxt = cnt - 8'h01;
      end else if (wrap) begin
        nxt = `RTACNT_FULL_SCALE;
      end else begin
        nxt = cnt;
      end
    end else if (!up_n && !dn_n && wrap) begin
      // Bounce between the ends
      if (!dir_down) begin
        if (cnt == `RTACNT_FULL_SCALE) begin
          dir = 1'b1;
          nxt = cnt - 8'h01;
        end else begin
          nxt = cnt + 8'h01;
        end
      end else begin
        if (cnt == `RTACNT_ZERO) begin
          dir = 1'b0;
          nxt = cnt + 8'h01;
        end else begin
          nxt = cnt - 8'h01;
        end
      end
    end else begin
      nxt = cnt;
    end
    return {dir, nxt};
  endfunction

  // Comparator synchroniser
  rtacnt_sync_if cmp_if();

  assign cmp_if.raw = {lower_threshold_comparator, upper_threshold_comparator, ramp_comparator};

  rtacnt_cmp_sync rtacnt_cmp_sync_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .cmp(cmp_if.snk)
  );

  logic ramp_s;
  logic upper_s;
  logic lower_s;

  assign ramp_s = cmp_if.synced[`RTACNT_CMP_RAMP];
  assign upper_s = cmp_if.synced[`RTACNT_CMP_UPPER];
  assign lower_s = cmp_if.synced[`RTACNT_CMP_LOWER];

  // Register port state
  rtacnt_conv_t conv_r;
  rtacnt_conv_t conv_nxt;
  logic sw_clear;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Counter and conversion state
  rtacnt_state_t state_r;
  rtacnt_state_t state_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic dir_down_r;
  logic dir_down_nxt;
  logic over_r;
  logic over_nxt;
  logic [7:0] dac_r;
  logic [7:0] dac_nxt;
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic oe_n_r;
  logic oe_n_nxt;

  // Effective controls after the conversion select
  logic eff_up_n;
  logic eff_dn_n;
  logic eff_wrap;
  logic count_en;
  logic dac_mode;
  logic restart;
  logic [8:0] step;

  // Writes to the control register
  always_comb begin
    conv_nxt = conv_r;
    sw_clear = 1'b0;
    if (reg_wr && reg_addr == `RTACNT_ADDR_CTRL) begin
      conv_nxt = rtacnt_conv_t'(reg_wdata[`RTACNT_CTRL_CONV_MSB:`RTACNT_CTRL_CONV_LSB]);
      sw_clear = reg_wdata[`RTACNT_CTRL_CLEAR_BIT];
    end
  end

  // Counter clears on pin reset or software clear
  assign restart = !ext_rst_n || sw_clear;

  // Pin mode honours the pins; the converter modes force their own controls
  always_comb begin
    eff_up_n = count_up_n;
    eff_dn_n = count_down_n;
    eff_wrap = wrap_sel;
    count_en = 1'b1;
    dac_mode = 1'b0;
    case (conv_r)
      RTACNT_CONV_RAMP: begin
        eff_up_n = 1'b0;
        eff_dn_n = 1'b1;
        eff_wrap = 1'b0;
        count_en = (state_r == RTACNT_ST_RUN) && !ramp_s;
      end
      RTACNT_CONV_TRACK: begin
        eff_up_n = upper_s;
        eff_dn_n = lower_s;
        eff_wrap = 1'b0;
        count_en = upper_s || lower_s;
      end
      default: begin
        dac_mode = !wrap_sel && !count_up_n && !count_down_n;
        count_en = !dac_mode;
      end
    endcase
  end

  assign step = rtacnt_step(count_r, eff_up_n, eff_dn_n, eff_wrap, dir_down_r);

  // Ramp conversion sequence
  always_comb begin
    state_nxt = state_r;
    over_nxt = over_r;
    case (state_r)
      RTACNT_ST_IDLE: begin
        over_nxt = 1'b0;
        if (conv_r == RTACNT_CONV_RAMP && !restart) begin
          state_nxt = RTACNT_ST_RUN;
        end
      end
      RTACNT_ST_RUN: begin
        if (conv_r != RTACNT_CONV_RAMP || restart) begin
          state_nxt = RTACNT_ST_IDLE;
        end else if (ramp_s) begin
          state_nxt = RTACNT_ST_DONE;
        end else if (count_r == `RTACNT_FULL_SCALE) begin
          state_nxt = RTACNT_ST_DONE;
          over_nxt = 1'b1;
        end
      end
      RTACNT_ST_DONE: begin
        if (conv_r != RTACNT_CONV_RAMP || restart) begin
          state_nxt = RTACNT_ST_IDLE;
        end
      end
      default: begin
        state_nxt = RTACNT_ST_IDLE;
      end
    endcase
  end

  // Counter, converter code and data port
  always_comb begin
    count_nxt = count_r;
    dir_down_nxt = dir_down_r;
    if (restart) begin
      count_nxt = `RTACNT_ZERO;
      dir_down_nxt = 1'b0;
    end else if (count_en) begin
      count_nxt = step[7:0];
      dir_down_nxt = step[8];
    end
    // Converter takes the port in data port mode, else the counter
    if (dac_mode) begin
      dac_nxt = data_port_in;
    end else begin
      dac_nxt = count_nxt;
    end
    dout_nxt = count_nxt;
    oe_n_nxt = dac_mode;
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == `RTACNT_ADDR_CTRL) begin
        rdata_nxt[`RTACNT_CTRL_CONV_MSB:`RTACNT_CTRL_CONV_LSB] = conv_r;
      end else if (reg_addr == `RTACNT_ADDR_STATUS) begin
        rdata_nxt[`RTACNT_STAT_STATE_MSB:`RTACNT_STAT_STATE_LSB] = state_r;
        rdata_nxt[`RTACNT_STAT_HALT_BIT] = !count_en;
        rdata_nxt[`RTACNT_STAT_DACMODE_BIT] = dac_mode;
        rdata_nxt[`RTACNT_STAT_DIRDOWN_BIT] = dir_down_r;
        rdata_nxt[`RTACNT_STAT_OVER_BIT] = over_r;
        rdata_nxt[`RTACNT_STAT_CODE_MSB:`RTACNT_STAT_CODE_LSB] = dac_r;
      end else if (reg_addr == `RTACNT_ADDR_COUNT) begin
        rdata_nxt[7:0] = count_r;
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_r <= RTACNT_CONV_PINS;
      state_r <= RTACNT_ST_IDLE;
      over_r <= 1'b0;
      count_r <= `RTACNT_ZERO;
      dir_down_r <= 1'b0;
      dac_r <= `RTACNT_CODE_RESET;
      dout_r <= `RTACNT_CODE_RESET;
      oe_n_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      conv_r <= conv_nxt;
      state_r <= state_nxt;
      over_r <= over_nxt;
      count_r <= count_nxt;
      dir_down_r <= dir_down_nxt;
      dac_r <= dac_nxt;
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs
  assign reg_rdata = rdata_r;
  assign dac_code = dac_r;
  assign data_port_out = dout_r;
  assign data_port_oe_n = oe_n_r;
  assign conv_done = (state_r == RTACNT_ST_DONE);

endmodule // rtacnt_top

// ==== sim/rtacnt_top_props.sv ====
// Port-level assertions for the ramp/tracking converter counter
module rtacnt_top_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic ext_rst_n,
  input wire logic wrap_sel,
  input wire logic count_up_n,
  input wire logic count_down_n,
  input wire logic ramp_comparator,
  input wire logic upper_threshold_comparator,
  input wire logic lower_threshold_comparator,
  input wire logic [7:0] data_port_in,
  input wire logic [7:0] data_port_out,
  input wire logic data_port_oe_n,
  input wire logic [7:0] dac_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] conv_r;
  logic [1:0] conv_nxt;
  logic pin_mode;
  // Shadow of the conversion field
  always_comb begin
    conv_nxt = conv_r;
    if (reg_wr && reg_addr == 8'h00) conv_nxt = reg_wdata[1:0];
  end
  always_ff @(posedge clk) begin
    conv_r <= sys_rst ? 2'h0 : conv_nxt;
  end
  assign pin_mode = conv_r == 2'h0 || conv_r == 2'h3;
  sequence pins_s(w, u, d);
    pin_mode && ext_rst_n && wrap_sel == w && count_up_n == u && count_down_n == d;
  endsequence
  sequence window_s;
    (conv_r == 2'h2 && ext_rst_n && upper_threshold_comparator && lower_threshold_comparator) [*3];
  endsequence
  sequence ramp_high_s;
    (conv_r == 2'h1 && ext_rst_n && ramp_comparator) [*3];
  endsequence
  a_pin_hold: assert property (pins_s(1, 1, 1) |=> data_port_out == $past(data_port_out))
    else $error("counter moved while pins ask for hold");
  a_pin_up: assert property (pins_s(1, 0, 1) |=> data_port_out == $past(data_port_out) + 8'h01)
    else $error("counter did not step up");
  a_pin_down: assert property (pins_s(1, 1, 0) |=> data_port_out == $past(data_port_out) - 8'h01)
    else $error("counter did not step down");
  a_stop_full: assert property (pins_s(0, 0, 1) and data_port_out == 8'hff |=> data_port_out == 8'hff)
    else $error("counter left full scale");
  a_stop_zero: assert property (pins_s(0, 1, 0) and data_port_out == 8'h00 |=> data_port_out == 8'h00)
    else $error("counter left zero");
  a_data_mode: assert property (pin_mode && !wrap_sel && !count_up_n && !count_down_n
    |=> dac_code == $past(data_port_in) && data_port_oe_n)
    else $error("data port mode not taken");
  a_ext_clear: assert property (!ext_rst_n |=> data_port_out == 8'h00)
    else $error("counter not cleared");
  a_dac_count: assert property (!data_port_oe_n |-> dac_code == data_port_out)
    else $error("converter code differs from counter");
  a_window_hold: assert property (window_s |=> $stable(dac_code))
    else $error("count moved inside window");
  a_ramp_halt: assert property (ramp_high_s |=> $stable(dac_code))
    else $error("ramp kept counting");
endmodule // rtacnt_top_props

bind rtacnt_top rtacnt_top_props rtacnt_top_props_inst (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .ext_rst_n, .wrap_sel, .count_up_n, .count_down_n, .ramp_comparator, .upper_threshold_comparator,
  .lower_threshold_comparator, .data_port_in, .data_port_out, .data_port_oe_n, .dac_code);

// ==== sim/rtacnt_cmp_model.sv ====
// Comparator and window comparator pair facing the converter output
module rtacnt_cmp_model #(
  parameter int DEADBAND = 2
) (
  input wire logic [7:0] dac_code,
  input wire logic signed [10:0] vin,
  output logic ramp_comparator,
  output logic upper_threshold_comparator,
  output logic lower_threshold_comparator
);
  timeunit 1ns;
  timeprecision 1ps;
  int code;
  assign code = int'(dac_code);
  // High once the staircase passes the input
  assign ramp_comparator = code > int'(vin);
  // Each low on its own side of the window, both high inside
  assign upper_threshold_comparator = !(int'(vin) > code + DEADBAND);
  assign lower_threshold_comparator = !(int'(vin) < code - DEADBAND);
endmodule // rtacnt_cmp_model

// ==== sim/test_ramp_tracking_adc_counter.sv ====
// Self-checking bench for the ramp/tracking converter counter
`include "rtacnt_defines.svh"
module test_ramp_tracking_adc_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ext_rst_n = 1'b1;
  logic wrap_sel = 1'b1;
  logic count_up_n = 1'b1;
  logic count_down_n = 1'b1;
  logic ramp_comparator, upper_threshold_comparator, lower_threshold_comparator;
  logic [7:0] data_port_in = 8'h00;
  logic [7:0] data_port_out, dac_code;
  logic data_port_oe_n, conv_done;
  logic signed [10:0] vin = 11'sd0;
  logic [31:0] rdv;
  int mismatches = 0;
  int compares = 0;
  rtacnt_top rtacnt_top_inst (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_rst_n, .wrap_sel, .count_up_n, .count_down_n, .ramp_comparator, .upper_threshold_comparator,
    .lower_threshold_comparator, .data_port_in, .data_port_out, .data_port_oe_n, .dac_code, .conv_done);
  rtacnt_cmp_model rtacnt_cmp_model_inst (.dac_code, .vin, .ramp_comparator, .upper_threshold_comparator,
    .lower_threshold_comparator);
  // Clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  // Hold a pin pattern for n edges, then back to hold
  task automatic pins(input logic w, input logic u, input logic d, input int n);
    @(posedge clk);
    wrap_sel <= w;
    count_up_n <= u;
    count_down_n <= d;
    repeat (n) @(posedge clk);
    wrap_sel <= 1'b1;
    count_up_n <= 1'b1;
    count_down_n <= 1'b1;
  endtask
  task automatic pulse;
    @(posedge clk);
    ext_rst_n <= 1'b0;
    @(posedge clk);
    ext_rst_n <= 1'b1;
  endtask
  // Wait for a code, then see that it stays
  task automatic settle(input logic [7:0] e);
    repeat (400) if (dac_code !== e) @(posedge clk);
    repeat (5) @(posedge clk);
    #1 chk("dac", dac_code, e);
  endtask
  function automatic bit near(input int t);
    int d;
    d = int'(dac_code) - t;
    return d <= 2 && d >= -2;
  endfunction
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h0c);
    chk("unmapped", rdv, 32'h0);
    pins(1'b1, 1'b0, 1'b1, 3);
    rd(`RTACNT_ADDR_COUNT);
    chk("count up", rdv, 32'h3);
    @(posedge clk);
    data_port_in <= 8'h5a;
    ext_rst_n <= 1'b0;
    pins(1'b0, 1'b0, 1'b0, 3);
    #1 chk("dac data", dac_code, 8'h5a);
    chk("oe_n", data_port_oe_n, 1'b1);
    @(posedge clk);
    ext_rst_n <= 1'b1;
    rd(`RTACNT_ADDR_COUNT);
    chk("cleared", rdv, 32'h0);
    pins(1'b1, 1'b1, 1'b0, 1);
    rd(`RTACNT_ADDR_COUNT);
    chk("wrap down", rdv, 32'hff);
    pins(1'b1, 1'b0, 1'b1, 1);
    rd(`RTACNT_ADDR_COUNT);
    chk("wrap up", rdv, 32'h0);
    pins(1'b0, 1'b1, 1'b0, 2);
    rd(`RTACNT_ADDR_COUNT);
    chk("stop zero", rdv, 32'h0);
    // Ramp: halts three codes past the input, two of them in the synchroniser
    vin <= 11'sd100;
    wr(`RTACNT_ADDR_CTRL, 32'h1);
    pulse;
    settle(8'h67);
    chk("done", conv_done, 1'b1);
    vin <= 11'sd300;
    pulse;
    settle(8'hff);
    rd(`RTACNT_ADDR_STATUS);
    chk("over", rdv[5], 1'b1);
    chk("status", rdv, 32'h0000_ff27);
    wr(`RTACNT_ADDR_CTRL, 32'h3);
    pins(1'b0, 1'b0, 1'b1, 2);
    rd(`RTACNT_ADDR_COUNT);
    chk("stop full", rdv, 32'hff);
    wr(`RTACNT_ADDR_CTRL, 32'h2);
    rd(`RTACNT_ADDR_CTRL);
    chk("ctrl", rdv, 32'h2);
    vin <= 11'sd60;
    repeat (400) if (!near(60)) @(posedge clk);
    repeat (10) @(posedge clk);
    #1 chk("window", near(60), 1'b1);
    vin <= -11'sd20;
    settle(8'h00);
    vin <= 11'sd300;
    settle(8'hff);
    // Software clear into pin mode, then bounce off full scale
    wr(`RTACNT_ADDR_CTRL, 32'h4);
    rd(`RTACNT_ADDR_CTRL);
    chk("ctrl clear", rdv, 32'h0);
    rd(`RTACNT_ADDR_COUNT);
    chk("sw clear", rdv, 32'h0);
    pins(1'b1, 1'b1, 1'b0, 2);
    pins(1'b1, 1'b0, 1'b1, 1);
    pins(1'b1, 1'b0, 1'b0, 2);
    rd(`RTACNT_ADDR_COUNT);
    chk("bounce", rdv, 32'hfd);
    rd(`RTACNT_ADDR_STATUS);
    chk("bounce status", rdv, 32'h0000_fd10);
    results;
  end
  // Watchdog
  initial begin
    #50000;
    mismatches++;
    results;
  end
endmodule // test_ramp_tracking_adc_counter
